// file: rtl/adcres_bank.sv
// Read-only bank of output voltage, battery voltage and battery current results
`timescale 1ns/10ps

// Overview of operation
// - Output voltage low byte read-only at 0x1D, 1 mV to 128 mV.
// - Battery voltage high byte at 0x1E: sign bit 7, result bits 14..8.
// - Results are two's complement; sign bit 0 positive, 1 negative.
// - Battery voltage low byte read-only at 0x1F, 1 mV to 128 mV.
// - Battery current high byte at 0x20: sign bit 7, result bits 14..8.
// - Battery current positive while charging, negative while discharging.
// - Register-reset command clears all bits; power-up undefined; host read-only.
// - Output voltage high byte at 0x1C: sign bit 7, result bits 14..8.
// - Battery current low byte read-only at 0x21, 1 mA to 128 mA.
module adcres_bank (
  input  wire logic                                 clock_i,    // 40 MHz control clock
  input  wire logic                                 rst_b_i,    // Async reset, active low
  input  wire logic                                 reg_rst_i,  // Register-reset command
  input  wire adcres_pkg::adcres_conv_t [2:0]       conv_i,     // Out volts, bat volts, bat amps
  input  wire adcres_pkg::adcres_rd_t               rd_i,       // Register read request
  output logic [7:0]                                rd_data_o,  // Read data, next cycle
  output logic                                      rd_hit_o    // Read hit a bank register
);
  import adcres_pkg::*;

  adcres_state_t s_q;
  adcres_state_t s_d;

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  // Host writes have no path here, so every register is read-only.
  always_comb begin
    s_d       = s_q;
    s_d.rhit  = 1'b0;
    s_d.rdata = UNMAP_DATA;
    // Whole 16-bit word lands in one edge, so both bytes move together
    for (int c = 0; c < CH_NUM; c++) begin
      if (conv_i[c].valid) begin
        s_d.res[c] = conv_i[c].value;
      end
    end
    if (rd_i.en) begin
      unique case (rd_i.addr)
        OFF_OUTV_HI: begin
          s_d.rdata              = s_q.res[CH_OUTV][15:8];
          s_d.rhit               = 1'b1;
          s_d.shadow[CH_OUTV]    = s_q.res[CH_OUTV][7:0];
          s_d.pend[CH_OUTV]      = 1'b1;
        end
        OFF_OUTV_LO: begin
          // Snapshot taken at the high read keeps the pair from one conversion
          s_d.rdata = s_q.pend[CH_OUTV] ? s_q.shadow[CH_OUTV]
                                        : s_q.res[CH_OUTV][7:0];
          s_d.rhit               = 1'b1;
          s_d.pend[CH_OUTV]      = 1'b0;
        end
        OFF_VBAT_HI: begin
          s_d.rdata              = s_q.res[CH_VBAT][15:8];
          s_d.rhit               = 1'b1;
          s_d.shadow[CH_VBAT]    = s_q.res[CH_VBAT][7:0];
          s_d.pend[CH_VBAT]      = 1'b1;
        end
        OFF_VBAT_LO: begin
          s_d.rdata = s_q.pend[CH_VBAT] ? s_q.shadow[CH_VBAT]
                                        : s_q.res[CH_VBAT][7:0];
          s_d.rhit               = 1'b1;
          s_d.pend[CH_VBAT]      = 1'b0;
        end
        OFF_BATI_HI: begin
          s_d.rdata              = s_q.res[CH_BATI][15:8];
          s_d.rhit               = 1'b1;
          s_d.shadow[CH_BATI]    = s_q.res[CH_BATI][7:0];
          s_d.pend[CH_BATI]      = 1'b1;
        end
        OFF_BATI_LO: begin
          s_d.rdata = s_q.pend[CH_BATI] ? s_q.shadow[CH_BATI]
                                        : s_q.res[CH_BATI][7:0];
          s_d.rhit               = 1'b1;
          s_d.pend[CH_BATI]      = 1'b0;
        end
        default: begin
          s_d.rdata              = UNMAP_DATA;
          s_d.rhit               = 1'b0;
        end
      endcase
    end
    // Reset command wins over a result landing in the same cycle
    if (reg_rst_i) begin
      for (int c = 0; c < CH_NUM; c++) begin
        s_d.res[c]    = RES_RST;
        s_d.shadow[c] = BYTE_RST;
      end
      s_d.pend = '0;
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  // Power-up content is undefined to software; zero is chosen for determinism
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs straight from flops
  assign rd_data_o = s_q.rdata;
  assign rd_hit_o  = s_q.rhit;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_outv_low_read: assert property (
    @(posedge clock_i) disable iff (!rst_b_i)
    (rd_i.en && rd_i.addr == OFF_OUTV_LO && !s_q.pend[CH_OUTV])
      |=> (rd_data_o == $past(s_q.res[CH_OUTV][7:0]) && rd_hit_o))
    else $error("output voltage low byte read wrong");

  a_vbat_high_read: assert property (
    @(posedge clock_i) disable iff (!rst_b_i)
    (rd_i.en && rd_i.addr == OFF_VBAT_HI)
      |=> (rd_data_o == $past(s_q.res[CH_VBAT][15:8])))
    else $error("vbat high byte read wrong");

  a_sign_follows: assert property (
    @(posedge clock_i) disable iff (!rst_b_i)
    (conv_i[CH_VBAT].valid && !reg_rst_i)
      |=> (s_q.res[CH_VBAT][SIGN_BIT] == $past(conv_i[CH_VBAT].value[SIGN_BIT])))
    else $error("vbat sign not captured");

  a_vbat_low_read: assert property (
    @(posedge clock_i) disable iff (!rst_b_i)
    (rd_i.en && rd_i.addr == OFF_VBAT_LO && !s_q.pend[CH_VBAT])
      |=> (rd_data_o == $past(s_q.res[CH_VBAT][7:0])))
    else $error("vbat low byte read wrong");

  a_bati_high_read: assert property (
    @(posedge clock_i) disable iff (!rst_b_i)
    (rd_i.en && rd_i.addr == OFF_BATI_HI)
      |=> (rd_data_o == $past(s_q.res[CH_BATI][15:8]) && rd_hit_o))
    else $error("battery current high byte read wrong");

  a_bati_discharge: assert property (
    @(posedge clock_i) disable iff (!rst_b_i)
    (conv_i[CH_BATI].valid && conv_i[CH_BATI].value[SIGN_BIT] && !reg_rst_i)
      ##1 (rd_i.en && rd_i.addr == OFF_BATI_HI && !conv_i[CH_BATI].valid && !reg_rst_i)
      |=> rd_data_o[7])
    else $error("discharge current not read as negative");

  a_bati_charge: assert property (
    @(posedge clock_i) disable iff (!rst_b_i)
    (conv_i[CH_BATI].valid && !conv_i[CH_BATI].value[SIGN_BIT] && !reg_rst_i)
      ##1 (rd_i.en && rd_i.addr == OFF_BATI_HI && !conv_i[CH_BATI].valid && !reg_rst_i)
      |=> !rd_data_o[7])
    else $error("charge current not read as positive");

  a_reset_clears: assert property (
    @(posedge clock_i) disable iff (!rst_b_i)
    reg_rst_i |=> (s_q.res == '0 && s_q.pend == '0 && s_q.shadow == '0))
    else $error("register reset did not clear bank");

  a_outv_high_read: assert property (
    @(posedge clock_i) disable iff (!rst_b_i)
    (rd_i.en && rd_i.addr == OFF_OUTV_HI)
      |=> (rd_data_o == $past(s_q.res[CH_OUTV][15:8])))
    else $error("output voltage high byte read wrong");

  a_bati_low_read: assert property (
    @(posedge clock_i) disable iff (!rst_b_i)
    (rd_i.en && rd_i.addr == OFF_BATI_LO && !s_q.pend[CH_BATI])
      |=> (rd_data_o == $past(s_q.res[CH_BATI][7:0])))
    else $error("battery current low byte read wrong");

  a_pair_coherent: assert property (
    @(posedge clock_i) disable iff (!rst_b_i)
    (rd_i.en && rd_i.addr == OFF_VBAT_HI && !reg_rst_i)
      ##1 (rd_i.en && rd_i.addr == OFF_VBAT_LO && !reg_rst_i)
      |=> (rd_data_o == $past(s_q.res[CH_VBAT][7:0], 2)))
    else $error("vbat pair not coherent");

  a_unmapped_zero: assert property (
    @(posedge clock_i) disable iff (!rst_b_i)
    (rd_i.en && (rd_i.addr < OFF_OUTV_HI || rd_i.addr > OFF_BATI_LO))
      |=> (!rd_hit_o && rd_data_o == UNMAP_DATA))
    else $error("unmapped read not zero");

  // Paired reads of the other two channels must come from one conversion too
  a_outv_pair_coherent: assert property (
    @(posedge clock_i) disable iff (!rst_b_i)
    (rd_i.en && rd_i.addr == OFF_OUTV_HI && !reg_rst_i)
      ##1 (rd_i.en && rd_i.addr == OFF_OUTV_LO && !reg_rst_i)
      |=> (rd_data_o == $past(s_q.res[CH_OUTV][7:0], 2) && rd_hit_o))
    else $error("output voltage pair not coherent");

  a_bati_pair_coherent: assert property (
    @(posedge clock_i) disable iff (!rst_b_i)
    (rd_i.en && rd_i.addr == OFF_BATI_HI && !reg_rst_i)
      ##1 (rd_i.en && rd_i.addr == OFF_BATI_LO && !reg_rst_i)
      |=> (rd_data_o == $past(s_q.res[CH_BATI][7:0], 2) && rd_hit_o))
    else $error("battery current pair not coherent");

  a_map_hit: assert property (
    @(posedge clock_i) disable iff (!rst_b_i)
    (rd_i.en && rd_i.addr >= OFF_OUTV_HI && rd_i.addr <= OFF_BATI_LO)
      |=> rd_hit_o)
    else $error("mapped read gave no hit");

  // A quiet port keeps the data lines at zero so stale bytes never leak
  a_idle_quiet: assert property (
    @(posedge clock_i) disable iff (!rst_b_i)
    !rd_i.en |=> (!rd_hit_o && rd_data_o == UNMAP_DATA))
    else $error("outputs not quiet without a read");

  a_high_snapshot: assert property (
    @(posedge clock_i) disable iff (!rst_b_i)
    (rd_i.en && rd_i.addr == OFF_OUTV_HI && !reg_rst_i)
      |=> (s_q.pend[CH_OUTV] && s_q.shadow[CH_OUTV] == $past(s_q.res[CH_OUTV][7:0])))
    else $error("high read did not take a snapshot");

  a_low_release: assert property (
    @(posedge clock_i) disable iff (!rst_b_i)
    (rd_i.en && rd_i.addr == OFF_VBAT_LO)
      |=> !s_q.pend[CH_VBAT])
    else $error("low read left the snapshot pending");

endmodule

// file: rtl/adcres_pkg.sv
// Package: constants and carrier types for the measurement result bank
package adcres_pkg;

  // ----------------------------------------------------------------
  // Channel indices and count
  // ----------------------------------------------------------------
  localparam int unsigned CH_NUM      = 3;
  localparam int unsigned CH_OUTV     = 0;
  localparam int unsigned CH_VBAT     = 1;
  localparam int unsigned CH_BATI     = 2;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses on the serial control port)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_OUTV_HI  = 8'h1C;
  localparam logic [7:0] OFF_OUTV_LO  = 8'h1D;
  localparam logic [7:0] OFF_VBAT_HI  = 8'h1E;
  localparam logic [7:0] OFF_VBAT_LO  = 8'h1F;
  localparam logic [7:0] OFF_BATI_HI  = 8'h20;
  localparam logic [7:0] OFF_BATI_LO  = 8'h21;

  // ----------------------------------------------------------------
  // Field layout and reset values
  // ----------------------------------------------------------------
  localparam int unsigned RES_W       = 16;
  localparam int unsigned SIGN_BIT    = 15;
  localparam logic [15:0] RES_RST     = 16'h0000;
  localparam logic [7:0]  BYTE_RST    = 8'h00;
  localparam logic [7:0]  UNMAP_DATA  = 8'h00;

  // One conversion result from the converter, signed two's complement
  typedef struct packed {
    logic              valid;
    logic [RES_W-1:0]  value;
  } adcres_conv_t;

  // Register read request from the serial control port
  typedef struct packed {
    logic        en;
    logic [7:0]  addr;
  } adcres_rd_t;

  // Whole state of the bank
  typedef struct packed {
    logic [CH_NUM-1:0][RES_W-1:0] res;
    logic [CH_NUM-1:0][7:0]       shadow;
    logic [CH_NUM-1:0]            pend;
    logic [7:0]                   rdata;
    logic                         rhit;
  } adcres_state_t;

endpackage

// file: dv/adcres_host.sv
// Host model: issues byte reads on the serial control port
`timescale 1ns/10ps
module adcres_host (
  input  wire logic              clock_i, // Control clock
  output adcres_pkg::adcres_rd_t rd_o     // Read request to the bank
);
  import adcres_pkg::*;

  initial rd_o = '0;

  // Request held across the sampling edge; back to back reads keep en high
  task automatic read(input logic [7:0] a);
    rd_o = '{en: 1'b1, addr: a};
    @(posedge clock_i);
    #1;
  endtask

  // Released port shows a scrambled address; a slow host idles longer
  task automatic idle(input int n);
    rd_o = '{en: 1'b0, addr: ~rd_o.addr};
    repeat (n) begin
      @(posedge clock_i);
      #1;
    end
  endtask
endmodule

// file: dv/adcres_bank_tb.sv
// Self-checking bench for the measurement result bank
`timescale 1ns/10ps
module adcres_bank_tb;
  import adcres_pkg::*;
  logic               clock_i   = 1'b0;
  logic               rst_b_i   = 1'b0;
  logic               reg_rst_i = 1'b0;
  adcres_conv_t [2:0] conv_i    = '0;
  adcres_rd_t         rd_i;
  logic [7:0]         rd_data_o;
  logic               rd_hit_o;
  logic [8:0]         exp_q[$];
  logic [8:0]         exp_v;
  logic [15:0]        res[3]    = '{default: 16'h0000};
  logic               pend      = 1'b0;
  int                 bad_count = 0;
  int                 check_count = 0;
  integer             seed      = 99;

  always #12.5 clock_i = ~clock_i;

  adcres_bank u_adcres_bank (.clock_i(clock_i), .rst_b_i(rst_b_i), .reg_rst_i(reg_rst_i),
    .conv_i(conv_i), .rd_i(rd_i), .rd_data_o(rd_data_o), .rd_hit_o(rd_hit_o));
  adcres_host u_adcres_host (.clock_i(clock_i), .rd_o(rd_i));

  // Note the expected hit and byte, then issue the read
  task automatic rd(input logic [7:0] a, input logic [8:0] e);
    exp_q.push_back(e);
    u_adcres_host.read(a);
  endtask

  // One conversion pulse; a result offered during register reset is lost
  task automatic conv(input int c, input logic [15:0] v);
    conv_i[c] = '{valid: 1'b1, value: v};
    if (!reg_rst_i) res[c] = v;
    @(posedge clock_i);
    #1;
    conv_i[c].valid = 1'b0;
  endtask

  // High then low byte of one channel, back to back
  task automatic pair(input int c);
    rd(OFF_OUTV_HI + 8'(2 * c), {1'b1, res[c][15:8]});
    rd(OFF_OUTV_LO + 8'(2 * c), {1'b1, res[c][7:0]});
    u_adcres_host.idle(1);
  endtask

  task automatic end_of_test();
    // Notes never answered count as one mismatch in all
    if (exp_q.size() != 0) bad_count++;
    $display("Checks %0d, mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Request seen at the edge; answer compared once settled, idle cycles expect zero
  always @(posedge clock_i) pend <= rd_i.en;
  always @(negedge clock_i) begin
    exp_v = 9'h000;
    if (pend && exp_q.size() > 0) exp_v = exp_q.pop_front();
    check_count++;
    if ({rd_hit_o, rd_data_o} !== exp_v) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, {rd_hit_o, rd_data_o}, exp_v);
    end
  end

  // Hang guard
  initial begin
    repeat (3000) @(posedge clock_i);
    bad_count++;
    end_of_test();
  end

  initial begin
    repeat (4) @(posedge clock_i);
    #1;
    rst_b_i = 1'b1;
    // Cleared bank and its unmapped neighbours
    for (int a = 8'h1B; a <= 8'h22; a++) rd(8'(a), {(a >= 8'h1C && a <= 8'h21), 8'h00});
    u_adcres_host.idle(2);
    $display("Test reset_state done");
    // Random results, battery current alternating charge and discharge
    for (int i = 0; i < 8; i++) begin
      conv(0, 16'($random(seed)) & 16'h7FFF);
      conv(1, 16'($random(seed)));
      conv(2, i[0] ? 16'h8000 | 16'($random(seed)) : 16'h7FFF & 16'($random(seed)));
      pair(2);
      pair(0);
      pair(1);
      // Fresh result, then a low read with no snapshot returns the live byte
      conv(i % 3, 16'($random(seed)));
      rd(OFF_OUTV_LO + 8'(2 * (i % 3)), {1'b1, res[i % 3][7:0]});
      u_adcres_host.idle(1);
    end
    $display("Test byte_map done");
    // New result lands on the same edge that takes the low read
    rd(OFF_VBAT_HI, {1'b1, res[1][15:8]});
    conv_i[1] = '{valid: 1'b1, value: ~res[1]};
    rd(OFF_VBAT_LO, {1'b1, res[1][7:0]});
    conv_i[1].valid = 1'b0;
    res[1] = ~res[1];
    pair(1);
    $display("Test coherence done");
    // Register reset wins over a result in the same cycle
    reg_rst_i = 1'b1;
    conv(2, 16'h1234);
    reg_rst_i = 1'b0;
    res = '{default: 16'h0000};
    for (int c = 0; c < 3; c++) pair(c);
    $display("Test register_reset done");
    end_of_test();
  end
endmodule
